/* File: inc/pic_defs.svh */
// constants for the priority interrupt channel block
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH
`define PIC_NCHAN        7
`define PIC_CHW          3
`define PIC_VEC_BASE     9'h028
`define PIC_VEC_SECOND   9'h001
`define PIC_FCODE_LSB    3
`define PIC_FCODE_W      3
`define PIC_FC_ZERO      3'h0
`define PIC_FC_ONE       3'h1
`define PIC_FC_DISPATCH  3'h2
`define PIC_FC_SEVEN     3'h7
`define PIC_PHYS_W       16
`define PIC_PHYS_IDW     4
`define PIC_PHYS_BUSADP  4'hf
`define PIC_ADDR_W       9
`define PIC_WORD_W       36
`endif

/* File: inc/pic_pkg.sv */
// types shared by the priority interrupt channel block
`include "pic_defs.svh"
package pic_pkg;
	// service action taken after the device word is read
	typedef enum logic [3:0] {
		PIC_ACT_NONE     = 4'h1,
		PIC_ACT_VECTOR   = 4'h2,
		PIC_ACT_DISPATCH = 4'h4,
		PIC_ACT_OTHER    = 4'h8
	} pic_act_e;

	// service sequencer states
	typedef enum logic [4:0] {
		PIC_ST_IDLE   = 5'h01,
		PIC_ST_SELECT = 5'h02,
		PIC_ST_WORD   = 5'h04,
		PIC_ST_EXEC   = 5'h08,
		PIC_ST_SECOND = 5'h10
	} pic_st_e;

	// per-channel flags
	typedef struct packed {
		logic [`PIC_NCHAN-1:0] armed;
		logic [`PIC_NCHAN-1:0] waiting;
		logic [`PIC_NCHAN-1:0] holding;
	} pic_flags_s;

	// service request handed to the microcode
	typedef struct packed {
		logic                   valid;
		logic [`PIC_CHW-1:0]    chan;
		logic [`PIC_ADDR_W-1:0] addr;
		pic_act_e               act;
		logic [`PIC_PHYS_IDW-1:0] phys;
	} pic_svc_s;

	// state of the top module, except the pending flag register
	typedef struct packed {
		pic_flags_s          fl;
		pic_st_e             st;
		logic [`PIC_CHW-1:0] cur;
		pic_svc_s            svc;
		logic                sel;
		logic [`PIC_CHW-1:0] sel_cs;
		logic                take;
		logic                resume2;
	} pic_state_s;
endpackage : pic_pkg

/* File: logic/pic_channels.sv */
// seven channel priority interrupt state and service sequencer
`timescale 1ns/1ps
`include "pic_defs.svh"
module pic_channels #(
	parameter int NCHAN = `PIC_NCHAN,
	parameter int CHW   = `PIC_CHW
) (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_nrst,
	// control write: arm, disarm, program request and clear-wait masks
	input  wire logic                      i_ctl_wr,
	input  wire logic [NCHAN-1:0]          i_ctl_arm,
	input  wire logic [NCHAN-1:0]          i_ctl_disarm,
	input  wire logic [NCHAN-1:0]          i_ctl_prog_req,
	input  wire logic [NCHAN-1:0]          i_ctl_clr_wait,
	// device and internal trigger levels per channel
	input  wire logic [NCHAN-1:0]          i_dev_trig,
	input  wire logic [NCHAN-1:0]          i_int_trig,
	// microcode break points
	input  wire logic                      i_brk_indirect,
	input  wire logic                      i_brk_between,
	input  wire logic                      i_brk_iter,
	input  wire logic                      i_brk_instr,
	// physical number answers and device word
	input  wire logic [`PIC_PHYS_W-1:0]    i_phys_bits,
	input  wire logic                      i_word_valid,
	input  wire logic [`PIC_WORD_W-1:0]    i_word,
	// result of the first and second vector instructions, and dismiss
	input  wire logic                      i_exec_done,
	input  wire logic                      i_exec_jsr,
	input  wire logic                      i_exec_blk_last,
	input  wire logic                      i_exec_skip_fail,
	input  wire logic                      i_dismiss,
	// outputs
	output logic [NCHAN-1:0]               o_channel_armed,
	output logic [NCHAN-1:0]               o_channel_waiting,
	output logic [NCHAN-1:0]               o_channel_holding,
	output logic                           o_int_pending,
	output logic                           o_select,
	output logic [CHW-1:0]                 o_sel_cs,
	output pic_pkg::pic_svc_s              o_svc,
	output logic                           o_fetch_second,
	output logic                           o_resume_second
);
	// ****************************************
	// state registers
	// ****************************************
	pic_pkg::pic_state_s state_reg;   // block state except the pending flag register
	pic_pkg::pic_state_s state_next;  // its next value

	logic            win_any;   // some request eligible
	logic [CHW-1:0]  win_idx;   // best eligible channel
	logic            hold_any;  // some channel holding
	logic [CHW-1:0]  hold_idx;  // current holding level
	logic            phys_any;  // some device answered
	logic [3:0]      phys_idx;  // winning physical number
	logic [NCHAN-1:0] elig;     // waiting, armed, not holding

	// ****************************************
	// arbitration
	// ****************************************
	// a holding channel's own new request waits
	assign elig = state_reg.fl.waiting & state_reg.fl.armed
		& ~state_reg.fl.holding;

	pic_prio_enc #(.N(NCHAN), .W(CHW)) u_win (
		.i_req (elig),
		.o_any (win_any),
		.o_idx (win_idx)
	);  // lowest number wins

	pic_prio_enc #(.N(NCHAN), .W(CHW)) u_hold (
		.i_req (state_reg.fl.holding),
		.o_any (hold_any),
		.o_idx (hold_idx)
	);

	pic_prio_enc #(.N(`PIC_PHYS_W), .W(`PIC_PHYS_IDW)) u_phys (
		.i_req (i_phys_bits),
		.o_any (phys_any),
		.o_idx (phys_idx)
	);  // bit 0 highest device rank

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [NCHAN-1:0] trig;  // triggers this cycle
		logic             above;  // winner outranks holding
		logic             brk;    // an interruptible point
		logic [`PIC_FCODE_W-1:0] fc;
		trig = '0;
		above = 1'b0;
		brk = 1'b0;
		fc = '0;
		state_next = state_reg;
		state_next.sel = 1'b0;
		state_next.take = 1'b0;
		state_next.svc.valid = 1'b0;
		state_next.resume2 = 1'b0;

		// arm and disarm by mask
		if (i_ctl_wr) begin
			state_next.fl.armed = (state_reg.fl.armed | i_ctl_arm)
				& ~i_ctl_disarm;
			state_next.fl.waiting = state_reg.fl.waiting
				& ~i_ctl_clr_wait;  // acknowledge
		end

		// triggers only land on armed channels
		trig = i_dev_trig | i_int_trig | (i_ctl_wr ? i_ctl_prog_req : '0);
		state_next.fl.waiting = state_next.fl.waiting
			| (trig & state_reg.fl.armed);  // set wins

		// dismiss clears the current holding level
		if (i_dismiss && hold_any) begin
			state_next.fl.holding[hold_idx] = 1'b0;
		end

		// break points where service may start
		brk = i_brk_indirect | i_brk_between | i_brk_iter
			| i_brk_instr;
		above = win_any && (!hold_any || win_idx < hold_idx);

		unique case (state_reg.st)
			pic_pkg::PIC_ST_IDLE: begin
				if (above && brk) begin
					state_next.cur = win_idx;
					state_next.sel = 1'b1;
					state_next.sel_cs = win_idx;
					state_next.resume2 = i_brk_between;
					state_next.st = pic_pkg::PIC_ST_SELECT;
				end
			end
			pic_pkg::PIC_ST_SELECT: begin
				state_next.sel = 1'b1;
				if (phys_any) begin
					state_next.svc.phys = phys_idx;
					state_next.st = pic_pkg::PIC_ST_WORD;
				end
			end
			pic_pkg::PIC_ST_WORD: begin
				state_next.sel = 1'b1;
				if (i_word_valid) begin
					fc = i_word[`PIC_FCODE_LSB +: `PIC_FCODE_W];
					state_next.sel = 1'b0;
					state_next.svc.valid = 1'b1;
					state_next.svc.chan = state_reg.cur;
					// first vector 40+2n
					state_next.svc.addr = `PIC_VEC_BASE
						+ {5'h00, state_reg.cur, 1'b0};
					state_next.st = pic_pkg::PIC_ST_IDLE;
					unique case (fc)
						`PIC_FC_ZERO, `PIC_FC_ONE, `PIC_FC_SEVEN: begin
							state_next.svc.act = pic_pkg::PIC_ACT_VECTOR;
							state_next.st = pic_pkg::PIC_ST_EXEC;
						end
						`PIC_FC_DISPATCH: begin
							// jump to device's physical address
							state_next.svc.act = pic_pkg::PIC_ACT_DISPATCH;
							state_next.svc.addr = i_word[`PIC_ADDR_W-1:0];
							state_next.fl.holding[state_reg.cur] = 1'b1;
							state_next.fl.waiting[state_reg.cur] = 1'b0;
						end
						default: begin
							state_next.svc.act = pic_pkg::PIC_ACT_OTHER;
						end
					endcase
				end
			end
			pic_pkg::PIC_ST_EXEC: begin
				if (i_exec_done) begin
					state_next.st = pic_pkg::PIC_ST_IDLE;
					if (i_exec_jsr) begin
						// save and hold; request moves to hold
						state_next.fl.holding[state_reg.cur] = 1'b1;
						state_next.fl.waiting[state_reg.cur] = 1'b0;
					end else if (i_exec_blk_last || i_exec_skip_fail) begin
						state_next.svc.valid = 1'b1;
						state_next.svc.addr = state_reg.svc.addr
							+ `PIC_VEC_SECOND;  // 41+2n
						state_next.take = 1'b1;
						state_next.st = pic_pkg::PIC_ST_SECOND;
					end
				end
			end
			pic_pkg::PIC_ST_SECOND: begin
				if (i_exec_done) begin
					// second vector saves state and holds
					state_next.fl.holding[state_reg.cur] = 1'b1;
					state_next.fl.waiting[state_reg.cur] = 1'b0;
					state_next.st = pic_pkg::PIC_ST_IDLE;
				end
			end
			default: begin
				state_next.st = pic_pkg::PIC_ST_IDLE;
			end
		endcase
		// waiting only meaningful on armed channel; holding still blocks lower levels when disarmed
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= '{fl: '0, st: pic_pkg::PIC_ST_IDLE, cur: '0,
				svc: '{valid: 1'b0, chan: '0, addr: '0,
				act: pic_pkg::PIC_ACT_NONE, phys: '0},
				sel: 1'b0, sel_cs: '0, take: 1'b0,
				resume2: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// output registers
	// ****************************************
	// pending flag registered so the output comes from a flip-flop
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_int_pending <= 1'b0;
		end else begin
			o_int_pending <= win_any && (!hold_any || win_idx < hold_idx);
		end
	end
	assign o_channel_armed = state_reg.fl.armed;
	assign o_channel_waiting = state_reg.fl.waiting;
	assign o_channel_holding = state_reg.fl.holding;
	assign o_select = state_reg.sel;
	assign o_sel_cs = state_reg.sel_cs;
	assign o_svc = state_reg.svc;
	assign o_fetch_second = state_reg.take;
	assign o_resume_second = state_reg.resume2;
endmodule : pic_channels

/* File: logic/pic_prio_enc.sv */
// lowest-index-wins priority encoder
`timescale 1ns/1ps
`include "pic_defs.svh"
module pic_prio_enc #(
	parameter int N  = 8,
	parameter int W  = 3
) (
	input  wire logic [N-1:0] i_req,
	output logic              o_any,
	output logic [W-1:0]      o_idx
);
	// ****************************************
	// scan from the top so bit 0 wins last
	// ****************************************
	always_comb begin
		o_any = 1'b0;
		o_idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (i_req[i]) begin
				o_any = 1'b1;
				o_idx = W'(i);
			end
		end
	end
endmodule : pic_prio_enc

/* File: sim/pic_channels_asserts.sv */
// checker on the channel block ports
`timescale 1ns/1ps
module pic_channels_asserts (
	input wire logic              i_clk_sys,
	input wire logic              i_nrst,
	input wire logic              i_ctl_wr,
	input wire logic [6:0]        i_ctl_arm,
	input wire logic [6:0]        i_ctl_disarm,
	input wire logic [6:0]        o_channel_armed,
	input wire logic [6:0]        o_channel_waiting,
	input wire logic [6:0]        o_channel_holding,
	input wire logic              o_select,
	input wire logic [2:0]        o_sel_cs,
	input wire pic_pkg::pic_svc_s o_svc,
	input wire logic              o_fetch_second
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	a_reset_flags_clear: assert property ($rose(i_nrst) |->
		{o_channel_armed, o_channel_waiting, o_channel_holding} == 21'h0)
		else $error("flags not clear after reset");
	a_disarmed_no_wait: assert property (!$past(i_ctl_wr) |->
		(o_channel_waiting & ~$past(o_channel_waiting)
		& ~$past(o_channel_armed)) == 7'h0)
		else $error("disarmed channel began waiting");
	a_arm_write_mask: assert property (i_ctl_wr
		&& (i_ctl_arm & i_ctl_disarm) == 7'h0 |=> o_channel_armed ==
		(($past(o_channel_armed) | $past(i_ctl_arm)) & ~$past(i_ctl_disarm)))
		else $error("armed mask wrong after write");
	a_sel_chan_range: assert property (o_select |-> o_sel_cs < 3'h7)
		else $error("select channel out of range");
	a_first_vec_addr: assert property (o_svc.valid && !o_fetch_second
		&& o_svc.act == pic_pkg::PIC_ACT_VECTOR
		|-> o_svc.addr == 9'h028 + {5'h0, o_svc.chan, 1'b0})
		else $error("first vector address wrong");
	a_second_vec_addr: assert property (o_fetch_second
		|-> o_svc.addr == 9'h029 + {5'h0, o_svc.chan, 1'b0})
		else $error("second vector address wrong");
	a_sel_best_wait: assert property ($rose(o_select) |->
		((o_channel_waiting & ((7'h1 << o_sel_cs) - 7'h1)) == 7'h0))
		else $error("selected channel not highest waiting");
	a_sel_above_hold: assert property ($rose(o_select) |->
		(({1'b0, o_channel_holding} & ((8'h2 << o_sel_cs) - 8'h1)) == 8'h0))
		else $error("selected channel not above holding level");
endmodule : pic_channels_asserts
bind pic_channels pic_channels_asserts u_chk (.i_clk_sys, .i_nrst,
	.i_ctl_wr, .i_ctl_arm, .i_ctl_disarm, .o_channel_armed,
	.o_channel_waiting, .o_channel_holding, .o_select, .o_sel_cs, .o_svc,
	.o_fetch_second);

/* File: sim/pic_channels_tb_top.sv */
// testbench for the priority interrupt channel block
`timescale 1ns/1ps
module pic_channels_tb_top;
	logic i_clk_sys, i_nrst, i_ctl_wr, i_brk, i_exec_done;
	logic i_jsr, i_blk_last, i_skip_fail, i_dismiss, i_word_valid;
	logic [6:0] i_ctl_arm, i_ctl_disarm, i_ctl_prog_req, i_ctl_clr_wait;
	logic [6:0] i_dev_trig, o_armed, o_waiting, o_holding;
	logic [15:0] i_phys_bits;
	logic [35:0] i_word;
	logic [2:0] fc, o_sel_cs;
	logic [3:0] id;
	logic o_select, o_fetch_second, o_pending;
	pic_pkg::pic_svc_s o_svc;
	int mismatches, comparisons, cyc;
	always #2 i_clk_sys = ~i_clk_sys;
	pic_channels u_dut (.i_clk_sys, .i_nrst, .i_ctl_wr, .i_ctl_arm,
		.i_ctl_disarm, .i_ctl_prog_req, .i_ctl_clr_wait, .i_dev_trig,
		.i_int_trig(7'h0), .i_brk_indirect(1'b0), .i_brk_between(1'b0),
		.i_brk_iter(1'b0), .i_brk_instr(i_brk), .i_phys_bits, .i_word_valid,
		.i_word, .i_exec_done, .i_exec_jsr(i_jsr), .i_exec_blk_last(i_blk_last),
		.i_exec_skip_fail(i_skip_fail), .i_dismiss, .o_channel_armed(o_armed),
		.o_channel_waiting(o_waiting), .o_channel_holding(o_holding),
		.o_int_pending(o_pending), .o_select, .o_sel_cs, .o_svc,
		.o_fetch_second,
		.o_resume_second());
	pic_dev_model u_dev (.i_clk_sys, .i_sel(o_select), .i_code(fc), .i_id(id),
		.o_phys_bits(i_phys_bits), .o_word_valid(i_word_valid), .o_word(i_word));
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	task automatic ctl(input logic [6:0] a, d, p, c);
		@(negedge i_clk_sys);
		{i_ctl_wr, i_ctl_arm, i_ctl_disarm, i_ctl_prog_req, i_ctl_clr_wait} = {1'b1, a, d, p, c};
		@(negedge i_clk_sys);
		{i_ctl_wr, i_ctl_arm, i_ctl_disarm, i_ctl_prog_req, i_ctl_clr_wait} = 29'h0;
		@(negedge i_clk_sys);
	endtask : ctl
	// break, wait for select and the service request
	task automatic serve(input logic [2:0] ch, c, input logic [3:0] d,
		input pic_pkg::pic_act_e act, input logic [8:0] adr);
		fc = c;
		id = d;
		i_brk = 1'b1;
		for (int n = 0; n < 30 && !o_select; n++) @(negedge i_clk_sys);
		i_brk = 1'b0;
		for (int n = 0; n < 30 && !o_svc.valid; n++) @(negedge i_clk_sys);
		chk({o_svc.valid, o_svc.chan, o_svc.addr, o_svc.act, o_svc.phys},
			{1'b1, ch, adr, act, d});
	endtask : serve
	task automatic exec(input logic j, l, s);
		@(negedge i_clk_sys);
		{i_exec_done, i_jsr, i_blk_last, i_skip_fail} = {1'b1, j, l, s};
		@(negedge i_clk_sys);
		{i_exec_done, i_jsr, i_blk_last, i_skip_fail} = 4'h0;
		if (!j) begin
			for (int n = 0; n < 30 && !o_fetch_second; n++) @(negedge i_clk_sys);
			chk(o_fetch_second, 1'b1);
			exec(1'b1, 1'b0, 1'b0);
		end
		repeat (2) @(negedge i_clk_sys);
	endtask : exec
	task automatic dismiss();
		i_dismiss = 1'b1;
		@(negedge i_clk_sys);
		i_dismiss = 1'b0;
		repeat (2) @(negedge i_clk_sys);
	endtask : dismiss
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		{i_clk_sys, i_nrst, i_ctl_wr, i_brk, i_exec_done, i_dismiss} = 6'h0;
		{i_jsr, i_blk_last, i_skip_fail, fc, id} = 10'h0;
		{i_ctl_arm, i_ctl_disarm, i_ctl_prog_req, i_ctl_clr_wait, i_dev_trig} = 35'h0;
		repeat (4) @(negedge i_clk_sys);
		i_nrst = 1'b1;
		chk({o_armed, o_waiting, o_holding, o_svc.act}, {21'h0, 4'h1});
		i_dev_trig = 7'h08;
		repeat (3) @(negedge i_clk_sys);
		chk(o_waiting, 7'h00);
		i_dev_trig = 7'h00;
		ctl(7'h7f, 7'h00, 7'h00, 7'h00);
		chk(o_armed, 7'h7f);
		ctl(7'h00, 7'h41, 7'h00, 7'h00);
		chk(o_armed, 7'h3e);
		i_dev_trig = 7'h08;
		repeat (2) @(negedge i_clk_sys);
		i_dev_trig = 7'h00;
		chk(o_waiting, 7'h08);
		ctl(7'h00, 7'h00, 7'h00, 7'h08);
		chk(o_waiting, 7'h00);
		$display("test 1 done");
		ctl(7'h00, 7'h00, 7'h24, 7'h00);
		serve(3'h2, 3'h0, 4'h9, pic_pkg::PIC_ACT_VECTOR, 9'h02c);
		exec(1'b1, 1'b0, 1'b0);
		chk({o_holding, o_waiting}, {7'h04, 7'h20});
		i_brk = 1'b1;
		repeat (6) @(negedge i_clk_sys);
		i_brk = 1'b0;
		chk(o_select, 1'b0);
		chk(o_pending, 1'b0);
		ctl(7'h00, 7'h00, 7'h02, 7'h00);
		serve(3'h1, 3'h7, 4'h3, pic_pkg::PIC_ACT_VECTOR, 9'h02a);
		exec(1'b0, 1'b0, 1'b1);
		chk(o_holding, 7'h06);
		dismiss();
		dismiss();
		chk(o_holding, 7'h00);
		$display("test 2 done");
		serve(3'h5, 3'h2, 4'h0, pic_pkg::PIC_ACT_DISPATCH, 9'h190);
		dismiss();
		ctl(7'h00, 7'h00, 7'h10, 7'h00);
		serve(3'h4, 3'h1, 4'hb, pic_pkg::PIC_ACT_VECTOR, 9'h030);
		exec(1'b0, 1'b1, 1'b0);
		dismiss();
		ctl(7'h00, 7'h00, 7'h08, 7'h00);
		// other codes keep the first vector address and take no hold
		serve(3'h3, 3'h3, 4'h8, pic_pkg::PIC_ACT_OTHER, 9'h02e);
		repeat (2) @(negedge i_clk_sys);
		chk({o_pending, o_holding}, {1'b1, 7'h00});
		$display("test 3 done");
		finish_test();
	end
endmodule : pic_channels_tb_top

/* File: sim/pic_dev_model.sv */
// peripheral controller model answering channel selects
`timescale 1ns/1ps
module pic_dev_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_sel,
	input  wire logic [2:0]  i_code,
	input  wire logic [3:0]  i_id,
	output logic [15:0]      o_phys_bits,
	output logic             o_word_valid,
	output logic [35:0]      o_word
);
	logic [1:0] stage_reg; // answer step
	initial begin
		stage_reg = 2'h0;
		o_phys_bits = 16'h0;
		o_word_valid = 1'b0;
		o_word = 36'h0;
	end
	// number answer, then word, then release
	always @(negedge i_clk_sys) begin
		o_word_valid <= 1'b0;
		case (stage_reg)
			2'h0: if (i_sel) begin
				o_phys_bits <= (16'h1 << i_id) | 16'h8000;
				stage_reg   <= 2'h1;
			end
			2'h1: begin
				o_word_valid <= 1'b1;
				o_word       <= {27'h0, 3'h6, i_code, 3'h0};
				stage_reg    <= 2'h2;
			end
			default: begin
				o_phys_bits <= 16'h0;
				if (!i_sel) stage_reg <= 2'h0;
			end
		endcase
	end
endmodule : pic_dev_model
